// File: scs_pkg.sv
// constants for the successive-approximation conversion sequencer
package scs_pkg;
  localparam int          ADC_BITS        = 18;
  localparam logic [4:0]  MSB_IDX         = 5'h11;
  localparam logic [17:0] CODE_MAX        = 18'h1ffff;
  localparam logic [17:0] CODE_MIN        = 18'h20000;
  localparam logic [17:0] MID_TRIAL       = 18'h20000;
  localparam logic [17:0] RESULT_RST      = 18'h00000;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          SAMPLE_PERIOD_NS = 1000;
  // longest time, so rounded down
  localparam int          SAMPLE_CYCLES   = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // one start step, one switch-open step, plus one step per bit
  localparam int          CONV_CYCLES     = ADC_BITS + 2;

  typedef enum logic [1:0] {
    SCS_ACQ     = 2'b00,
    SCS_OPEN_SW = 2'b01,
    SCS_TRIAL   = 2'b10
  } scs_state_t;
endpackage

// File: scs_sequencer.sv
// conversion sequencer of an 18-bit successive-approximation converter
`timescale 1ns/1ns
module scs_sequencer (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        convert_strobe,
  input  wire logic        serial_in_mode_select,
  input  wire logic        comp_above,
  input  wire logic        in_over_range,
  input  wire logic        in_under_range,
  output logic             pos_array_ground_switch,
  output logic             neg_array_ground_switch,
  output logic             array_on_inputs,
  output logic [17:0]      dac_code,
  output logic [17:0]      result,
  output logic             result_valid,
  output logic             busy_indicator,
  output logic             chain_mode,
  output logic             powered_down
);

  scs_pkg::scs_state_t state;
  scs_pkg::scs_state_t next_state;
  logic        cnv_prev;
  logic [4:0]  bit_idx;
  logic [17:0] next_dac_code;
  logic [17:0] next_result;
  logic [17:0] decided;
  logic [4:0]  next_bit_idx;
  logic        next_result_valid;
  logic        next_busy_indicator;
  logic        next_chain_mode;
  logic        next_ground_sw;
  logic        next_on_inputs;
  logic        start;

  // only an edge seen while acquiring starts work; later edges are dropped
  assign start = convert_strobe && !cnv_prev &&
                 state == scs_pkg::SCS_ACQ;

  // next-state and datapath; the comparator is read in the same cycle the
  // trial code stands, so each trial costs exactly one clock
  always_comb begin
    next_state          = state;
    next_bit_idx        = bit_idx;
    next_dac_code       = dac_code;
    next_result         = result;
    next_result_valid   = 1'b0;
    next_busy_indicator = 1'b0;
    next_chain_mode     = chain_mode;
    decided             = dac_code;
    unique case (state)
      scs_pkg::SCS_ACQ: begin
        if (start) begin
          next_state      = scs_pkg::SCS_OPEN_SW;
          next_chain_mode = !serial_in_mode_select;
        end
      end
      scs_pkg::SCS_OPEN_SW: begin
        // ground switches are already open; arrays move on the next edge
        next_state    = scs_pkg::SCS_TRIAL;
        next_bit_idx  = scs_pkg::MSB_IDX;
        next_dac_code = scs_pkg::MID_TRIAL;
      end
      scs_pkg::SCS_TRIAL: begin
        // keep the trial bit only if the input still lies above the dac
        decided[bit_idx] = comp_above;
        if (bit_idx == 5'h00) begin
          next_state        = scs_pkg::SCS_ACQ;
          next_result_valid = 1'b1;
          // offset binary becomes two's complement by flipping the sign bit
          next_result = {~decided[17], decided[16:0]};
          if (in_over_range) begin
            next_result = scs_pkg::CODE_MAX;
          end else if (in_under_range) begin
            next_result = scs_pkg::CODE_MIN;
          end
          next_busy_indicator = chain_mode ||
                                !serial_in_mode_select ||
                                !convert_strobe;
          next_dac_code = decided;
        end else begin
          next_bit_idx  = bit_idx - 5'h01;
          next_dac_code = decided | (18'h00001 << (bit_idx - 5'h01));
        end
      end
      default: begin
        next_state = scs_pkg::SCS_ACQ;
      end
    endcase
    next_ground_sw = (next_state == scs_pkg::SCS_ACQ);
    next_on_inputs = (next_state != scs_pkg::SCS_TRIAL);
  end

  // registers; outputs follow the state so they change with it
  always_ff @(posedge clk) begin
    if (srst) begin
      state                   <= scs_pkg::SCS_ACQ;
      cnv_prev                <= 1'b1; // held strobe is no edge
      bit_idx                 <= scs_pkg::MSB_IDX;
      dac_code                <= scs_pkg::MID_TRIAL;
      result                  <= scs_pkg::RESULT_RST;
      result_valid            <= 1'b0;
      busy_indicator          <= 1'b0;
      chain_mode              <= 1'b0;
      pos_array_ground_switch <= 1'b1;
      neg_array_ground_switch <= 1'b1;
      array_on_inputs         <= 1'b1;
      powered_down            <= 1'b1;
    end else begin
      state                   <= next_state;
      cnv_prev                <= convert_strobe;
      bit_idx                 <= next_bit_idx;
      dac_code                <= next_dac_code;
      result                  <= next_result;
      result_valid            <= next_result_valid;
      busy_indicator          <= next_busy_indicator;
      chain_mode              <= next_chain_mode;
      pos_array_ground_switch <= next_ground_sw;
      neg_array_ground_switch <= next_ground_sw;
      array_on_inputs         <= next_on_inputs;
      powered_down            <= next_ground_sw;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // an edge in acquisition opens the switches next cycle
  a_start_on_edge: assert property (
    start |=> state == scs_pkg::SCS_OPEN_SW && !pos_array_ground_switch)
    else $error("strobe edge did not start a conversion");

  // switches open one cycle before the arrays leave the inputs
  a_switch_order: assert property (
    $fell(pos_array_ground_switch) |->
      array_on_inputs && !neg_array_ground_switch ##1 !array_on_inputs)
    else $error("arrays moved before ground switches opened");

  // first trial is the midpoint, so the msb is tried first
  a_msb_first: assert property (
    state == scs_pkg::SCS_OPEN_SW |=> dac_code == 18'h20000 &&
      bit_idx == 5'h11)
    else $error("first trial is not the msb");

  // the whole conversion takes twenty clocks, result of this start
  a_conv_length: assert property (
    start |-> ##20 result_valid && powered_down)
    else $error("conversion did not finish in twenty clocks");

  // no result may appear in the first sixteen cycles after the start
  a_no_latency: assert property (
    start |=> !result_valid [*8] ##1 !result_valid [*8])
    else $error("result appeared during a conversion");

  // completion returns to acquisition with switches closed
  a_end_state: assert property (
    result_valid |-> state == scs_pkg::SCS_ACQ && array_on_inputs &&
      pos_array_ground_switch)
    else $error("completion did not return to acquisition");

  // overrange wins and saturates to the largest code
  a_sat_high: assert property (
    state == scs_pkg::SCS_TRIAL && bit_idx == 5'h00 && in_over_range
      |=> result == 18'h1ffff)
    else $error("overrange did not saturate high");

  // underrange alone saturates to the smallest code
  a_sat_low: assert property (
    state == scs_pkg::SCS_TRIAL && bit_idx == 5'h00 && !in_over_range &&
      in_under_range |=> result == 18'h20000)
    else $error("underrange did not saturate low");

  // sign bit is the inverse of the offset-binary msb
  a_twos_comp: assert property (
    result_valid && !$past(in_over_range) && !$past(in_under_range)
      |-> result[17] == !dac_code[17])
    else $error("result is not two's complement");

  // mode is the inverse of the mode input at the start edge
  a_mode_sample: assert property (
    start |=> chain_mode == !$past(serial_in_mode_select))
    else $error("interface mode not sampled at strobe edge");

  // select-mode busy follows the two inputs at completion
  a_busy_select: assert property (
    result_valid && !chain_mode |->
      busy_indicator == (!$past(serial_in_mode_select) ||
                         !$past(convert_strobe)))
    else $error("select-mode busy enable wrong");

  // idle between conversions is the powered-down state
  a_idle_power: assert property (
    state == scs_pkg::SCS_ACQ |-> powered_down)
    else $error("not powered down while idle");

  // chain mode always raises busy together with the result
  a_busy_chain: assert property (
    result_valid && chain_mode |-> busy_indicator)
    else $error("chain-mode busy missing at completion");

  // each trial keeps the compared bit as the comparator said, sets the next
  a_trial_step: assert property (
    state == scs_pkg::SCS_TRIAL && bit_idx != 5'h00 |=>
      dac_code[bit_idx] && dac_code[bit_idx + 5'h01] == $past(comp_above))
    else $error("trial step did not follow the comparator");

  // the result moves only at a completion; reset release is skipped
  a_result_hold: assert property (
    !result_valid && !$past(srst) |-> $stable(result))
    else $error("result changed outside a completion");

endmodule

// File: scs_host_model.sv
// host controller and comparator model facing the sequencer
`timescale 1ns/1ns
module scs_host_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        go,
  input  wire logic        hold,
  input  wire logic [17:0] target,
  input  wire logic [17:0] dac_code,
  input  wire logic        result_valid,
  output logic             convert_strobe,
  output logic             comp_above
);
  logic pending;
  // input sits half a step above the target code, so no compare ties
  assign comp_above = ({target ^ 18'h20000, 1'b1} > {dac_code, 1'b0});
  // one strobe edge per conversion, none before the answer came
  always_ff @(posedge clk) begin
    if (srst) begin
      convert_strobe <= 1'b0;
      pending        <= 1'b0;
    end else if (go && !pending && !convert_strobe) begin
      convert_strobe <= 1'b1;
      pending        <= 1'b1;
    end else begin
      if (convert_strobe && (!hold || result_valid))
        convert_strobe <= 1'b0;
      if (result_valid)
        pending <= 1'b0;
    end
  end
endmodule

// File: scs_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module scs_sequencer_test;
  logic        clk, srst, go, hold, mode, over, under, strobe, comp;
  logic        sw_p, sw_n, on_in, rv, busy, chain, pdn;
  logic [17:0] target, dac, result;
  int          miscompares, num_checks;

  scs_host_model u_host (.clk(clk), .srst(srst), .go(go), .hold(hold),
    .target(target), .dac_code(dac), .result_valid(rv),
    .convert_strobe(strobe), .comp_above(comp));
  scs_sequencer u_dut (.clk(clk), .srst(srst), .convert_strobe(strobe),
    .serial_in_mode_select(mode), .comp_above(comp), .in_over_range(over),
    .in_under_range(under), .pos_array_ground_switch(sw_p),
    .neg_array_ground_switch(sw_n), .array_on_inputs(on_in), .dac_code(dac),
    .result(result), .result_valid(rv), .busy_indicator(busy),
    .chain_mode(chain), .powered_down(pdn));

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: code %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one conversion; cycle n counts edges after the start edge
  task automatic convert(input logic [17:0] code, input logic m0, m1, h,
                         input logic ov, un, input logic [17:0] exp,
                         input logic eb);
    @(posedge clk);
    {target, mode, hold, over, under, go} <= {code, m0, h, ov, un, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    for (int n = 1; n <= 21; n++) begin
      @(posedge clk);
      if (n == 2) mode <= m1;
      #1;
      if (n == 1) check_bit(sw_p | sw_n | ~on_in | pdn, 1'b0);
      if (n == 1) check_bit(chain, ~m0);
      if (n == 2) check({on_in, dac[16:0]}, 18'h00000);
      if (n == 3) check(dac, {code[17] ^ 1'b1, 17'h10000});
      check_bit(rv, n == 20);
      if (n == 20) check_bit(sw_n & pdn & on_in, 1'b1);
      if (n == 20) check(result, exp);
      if (n == 20) check_bit(busy, eb);
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic reset_values;
    check_bit(sw_p & sw_n & on_in & pdn & ~rv & ~busy & ~chain, 1'b1);
    check({result ^ dac}, 18'h20000);
  endtask
  task automatic code_table;
    logic [17:0] codes [8] = '{18'h00000, 18'h00001, 18'h3ffff, 18'h1ffff,
                               18'h20000, 18'h20001, 18'h15555, 18'h2aaaa};
    foreach (codes[i]) convert(codes[i], 0, 0, 1, 0, 0, codes[i], 1);
  endtask
  task automatic saturation;
    convert(18'h00005, 0, 0, 1, 1, 0, 18'h1ffff, 1);
    convert(18'h3fffb, 0, 0, 1, 0, 1, 18'h20000, 1);
    convert(18'h00123, 0, 0, 1, 1, 1, 18'h1ffff, 1);
  endtask
  task automatic busy_modes;
    convert(18'h00042, 1, 1, 1, 0, 0, 18'h00042, 0);
    convert(18'h3ff00, 1, 0, 1, 0, 0, 18'h3ff00, 1);
    convert(18'h01000, 1, 1, 0, 0, 0, 18'h01000, 1);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // the whole run needs under 400 cycles; give it ample room
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    {srst, go, hold, mode, over, under, target} = {6'h20, 18'h00000};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    reset_values();
    code_table();
    saturation();
    busy_modes();
    complete_run();
  end
endmodule
